// File: phs_core.sv
// Header suppression and restoration engine with APB rule table
`timescale 1ns/10ps
`include "phs_regs.svh"
module phs_core #(
  parameter int NRULE = 4,
  parameter int FLDMAX = 64,
  parameter int SIDW = 14
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic inValid,
  input wire phs_pkg::phs_byte_t inData,
  input wire logic inFirst,
  input wire logic inLast,
  input wire logic inElem,
  input wire logic [7:0] inIndex,
  input wire logic [SIDW-1:0] inSid,
  input wire logic [1:0] inRule,
  input wire logic inMulti,
  output logic outValid,
  output phs_pkg::phs_byte_t outData,
  output logic outFirst,
  output logic outLast,
  output logic outElem,
  output logic [7:0] outIndex,
  output logic outDrop,
  output logic lookupErr
);
  import phs_pkg::*;
  localparam int RW = $clog2(NRULE);
  localparam int FW = $clog2(FLDMAX);
  logic upMode_ff, nxt_upMode;
  logic [RW-1:0] sel_ff, nxt_sel;
  logic [NRULE-1:0] valid_ff, nxt_valid, vfy_ff, nxt_vfy;
  logic [NRULE-1:0] hasTpl_ff, nxt_hasTpl, hasSz_ff, nxt_hasSz;
  logic [7:0] idx_ff [NRULE], nxt_idx [NRULE];
  logic [SIDW-1:0] sid_ff [NRULE], nxt_sid [NRULE];
  logic [FW:0] size_ff [NRULE], nxt_size [NRULE];
  logic [FLDMAX-1:0] mask_ff [NRULE], nxt_mask [NRULE];
  logic [7:0] tpl_ff [NRULE][FLDMAX], nxt_tpl [NRULE][FLDMAX];
  logic [FW-1:0] tplA_ff, nxt_tplA;
  logic [15:0] errCnt_ff, nxt_errCnt;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  phs_state_e st_ff, nxt_st;
  logic [FW:0] pos_ff, nxt_pos;
  logic [RW-1:0] cur_ff, nxt_cur;
  logic pass_ff, nxt_pass;
  logic [7:0] hold_ff [FLDMAX], nxt_hold [FLDMAX];
  logic oV_ff, nxt_oV, oF_ff, nxt_oF, oL_ff, nxt_oL, oE_ff, nxt_oE;
  logic oD_ff, nxt_oD, lErr_ff, nxt_lErr;
  logic [7:0] oDat_ff, nxt_oDat, oIdx_ff, nxt_oIdx;
  logic busWr, busRd, hit;
  logic [RW-1:0] hitIdx;
  logic full;

  assign busWr = psel && penable && pwrite && !pready_ff;
  assign busRd = psel && penable && !pwrite && !pready_ff;
  assign full = hasTpl_ff[sel_ff] && hasSz_ff[sel_ff];

  // Receive lookup by identifier and index upstream, index alone downstream
  always_comb begin
    hit = 1'b0;
    hitIdx = '0;
    for (int r = 0; r < NRULE; r++) begin
      if (valid_ff[r] && idx_ff[r] == inIndex &&
          (!upMode_ff || sid_ff[r] == inSid) && !hit) begin
        hit = 1'b1;
        hitIdx = RW'(r);
      end
    end
  end

  // Register bus and rule table
  always_comb begin
    nxt_upMode = upMode_ff;
    nxt_sel = sel_ff;
    nxt_valid = valid_ff;
    nxt_vfy = vfy_ff;
    nxt_hasTpl = hasTpl_ff;
    nxt_hasSz = hasSz_ff;
    nxt_idx = idx_ff;
    nxt_sid = sid_ff;
    nxt_size = size_ff;
    nxt_mask = mask_ff;
    nxt_tpl = tpl_ff;
    nxt_tplA = tplA_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = psel && penable && !pready_ff;
    nxt_pslverr = 1'b0;
    if (busWr) begin
      if (paddr == `PHS_CTRL_OFS) begin
        nxt_upMode = pwdata[`PHS_CTRL_UP_BIT];
      end else if (paddr == `PHS_SEL_OFS) begin
        nxt_sel = pwdata[RW-1:0];
      end else if (paddr == `PHS_CFG_OFS) begin
        if (pwdata[`PHS_CFG_DEL_BIT]) begin
          nxt_valid[sel_ff] = 1'b0;
          nxt_hasTpl[sel_ff] = 1'b0;
          nxt_hasSz[sel_ff] = 1'b0;
          nxt_vfy[sel_ff] = 1'b0;
          nxt_mask[sel_ff] = '1;
        end else if (full) begin
          nxt_pslverr = 1'b1;
        end else begin
          nxt_valid[sel_ff] = 1'b1;
          nxt_idx[sel_ff] = pwdata[7:0];
          nxt_sid[sel_ff] = pwdata[8 +: SIDW];
          nxt_vfy[sel_ff] = pwdata[`PHS_CFG_VFY_BIT];
          // size may arrive apart
          // Size field stops below the size-valid flag
          if (pwdata[`PHS_CFG_SZ_BIT]) begin
            nxt_size[sel_ff] = (FW+1)'(pwdata[26:22]);
            nxt_hasSz[sel_ff] = 1'b1;
          end
          if (pwdata[`PHS_CFG_TPL_BIT]) begin
            nxt_hasTpl[sel_ff] = 1'b1;
          end
        end
      end else if (paddr == `PHS_MASK_OFS) begin
        if (full) begin
          nxt_pslverr = 1'b1;
        end else begin
          nxt_mask[sel_ff] = {{(FLDMAX > 32 ? FLDMAX-32 : 0){1'b1}},
                              pwdata[31:0]};
        end
      end else if (paddr == `PHS_TPLA_OFS) begin
        nxt_tplA = pwdata[FW-1:0];
      end else if (paddr == `PHS_TPLD_OFS) begin
        if (full) begin
          nxt_pslverr = 1'b1;
        end else begin
          nxt_tpl[sel_ff][tplA_ff] = pwdata[7:0];
          nxt_tplA = tplA_ff + FW'(1);
        end
      end else if (paddr != `PHS_STAT_OFS && paddr != `PHS_CNT_OFS) begin
        nxt_pslverr = 1'b1;
      end
    end
    if (busRd) begin
      if (paddr == `PHS_CTRL_OFS) begin
        nxt_prdata = {31'h0, upMode_ff};
      end else if (paddr == `PHS_SEL_OFS) begin
        nxt_prdata = 32'(sel_ff);
      end else if (paddr == `PHS_STAT_OFS) begin
        nxt_prdata = {28'h0, full, hasTpl_ff[sel_ff], hasSz_ff[sel_ff],
                      valid_ff[sel_ff]};
      end else if (paddr == `PHS_CNT_OFS) begin
        nxt_prdata = {16'h0, errCnt_ff};
      end else if (paddr == `PHS_TPLA_OFS) begin
        nxt_prdata = 32'(tplA_ff);
      end else begin
        nxt_prdata = 32'h0;
        nxt_pslverr = (paddr != `PHS_CFG_OFS && paddr != `PHS_MASK_OFS &&
                       paddr != `PHS_TPLD_OFS);
      end
    end
  end

  // Packet engine
  always_comb begin
    nxt_st = st_ff;
    nxt_pos = pos_ff;
    nxt_cur = cur_ff;
    nxt_pass = pass_ff;
    nxt_hold = hold_ff;
    nxt_oV = 1'b0;
    nxt_oF = 1'b0;
    nxt_oL = 1'b0;
    nxt_oE = oE_ff;
    nxt_oIdx = oIdx_ff;
    nxt_oDat = oDat_ff;
    nxt_oD = 1'b0;
    nxt_lErr = 1'b0;
    nxt_errCnt = errCnt_ff;
    case (st_ff)
      PHS_IDLE, PHS_DROP: begin
        if (inValid && inFirst) begin
          nxt_pos = '0;
          if (upMode_ff) begin
            nxt_cur = inRule;
            nxt_pass = inMulti || !valid_ff[inRule] || !hasSz_ff[inRule];
            nxt_oE = 1'b0;
            nxt_oIdx = idx_ff[inRule];
            nxt_hold[0] = inData;
            nxt_st = PHS_FLD;
          end else if (!inElem) begin
            nxt_pass = 1'b1;
            nxt_oV = 1'b1;
            nxt_oF = 1'b1;
            nxt_oL = inLast;
            nxt_oDat = inData;
            nxt_oE = 1'b0;
            nxt_st = inLast ? PHS_IDLE : PHS_BODY;
          end else if (!hit) begin
            nxt_oD = 1'b1;
            nxt_lErr = 1'b1;
            nxt_errCnt = errCnt_ff + 16'h1;
            nxt_st = inLast ? PHS_IDLE : PHS_DROP;
          end else begin
            nxt_cur = hitIdx;
            // First kept byte waits in hold until its slot
            nxt_pass = 1'b1;
            nxt_oE = 1'b0;
            nxt_hold[0] = inData;
            nxt_st = PHS_HDR;
          end
        end
      end
      PHS_FLD: begin
        if (pos_ff + 1'b1 >= size_ff[cur_ff]) begin
          nxt_st = PHS_BODY;
          nxt_pos = '0;
        end else if (inValid) begin
          nxt_pos = pos_ff + 1'b1;
          nxt_hold[FW'(pos_ff + 1'b1)] = inData;
        end
        if (nxt_st == PHS_BODY && !pass_ff) begin
          for (int b = 0; b < FLDMAX; b++) begin
            // set mask bit marks suppressed byte
            if (!vfy_ff[cur_ff] && mask_ff[cur_ff][b] &&
                b < size_ff[cur_ff] && hold_ff[b] != tpl_ff[cur_ff][b]) begin
              nxt_pass = 1'b1;
            end
          end
          nxt_oE = !nxt_pass;
        end
      end
      PHS_HDR: begin
        if (pos_ff >= size_ff[cur_ff]) begin
          nxt_st = PHS_BODY;
          if (pass_ff) begin
            nxt_oV = 1'b1;
            nxt_oF = (pos_ff == '0);
            nxt_oDat = hold_ff[0];
            nxt_pass = 1'b0;
          end
        end else if (mask_ff[cur_ff][FW'(pos_ff)]) begin
          nxt_oV = 1'b1;
          nxt_oF = (pos_ff == '0);
          nxt_oDat = tpl_ff[cur_ff][FW'(pos_ff)];
          nxt_pos = pos_ff + 1'b1;
        end else if (pass_ff) begin
          nxt_oV = 1'b1;
          nxt_oF = (pos_ff == '0);
          nxt_oDat = hold_ff[0];
          nxt_pos = pos_ff + 1'b1;
          nxt_pass = 1'b0;
        end else if (inValid) begin
          nxt_oV = 1'b1;
          nxt_oF = (pos_ff == '0);
          nxt_oDat = inData;
          nxt_pos = pos_ff + 1'b1;
        end
      end
      PHS_BODY: begin
        if (upMode_ff && pos_ff < size_ff[cur_ff]) begin
          if (pass_ff || !mask_ff[cur_ff][FW'(pos_ff)]) begin
            nxt_oV = 1'b1;
            nxt_oDat = hold_ff[FW'(pos_ff)];
            nxt_oF = (pos_ff == '0);
          end
          nxt_pos = pos_ff + 1'b1;
        end else if (inValid) begin
          nxt_oV = 1'b1;
          nxt_oDat = inData;
          nxt_oL = inLast;
          nxt_st = inLast ? PHS_IDLE : PHS_BODY;
        end
      end
      default: nxt_st = PHS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      upMode_ff <= 1'b0;
      sel_ff <= '0;
      valid_ff <= '0;
      vfy_ff <= '0;
      hasTpl_ff <= '0;
      hasSz_ff <= '0;
      tplA_ff <= '0;
      errCnt_ff <= 16'h0;
      prdata_ff <= `PHS_CTRL_RST;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      st_ff <= PHS_IDLE;
      pos_ff <= '0;
      cur_ff <= '0;
      pass_ff <= 1'b0;
      oV_ff <= 1'b0;
      oF_ff <= 1'b0;
      oL_ff <= 1'b0;
      oE_ff <= 1'b0;
      oD_ff <= 1'b0;
      lErr_ff <= 1'b0;
      oDat_ff <= 8'h00;
      oIdx_ff <= 8'h00;
      for (int r = 0; r < NRULE; r++) begin
        idx_ff[r] <= 8'h00;
        sid_ff[r] <= '0;
        size_ff[r] <= '0;
        mask_ff[r] <= '1;
        for (int b = 0; b < FLDMAX; b++) begin
          tpl_ff[r][b] <= 8'h00;
        end
      end
      for (int b = 0; b < FLDMAX; b++) begin
        hold_ff[b] <= 8'h00;
      end
    end else begin
      upMode_ff <= nxt_upMode;
      sel_ff <= nxt_sel;
      valid_ff <= nxt_valid;
      vfy_ff <= nxt_vfy;
      hasTpl_ff <= nxt_hasTpl;
      hasSz_ff <= nxt_hasSz;
      tplA_ff <= nxt_tplA;
      errCnt_ff <= nxt_errCnt;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      st_ff <= nxt_st;
      pos_ff <= nxt_pos;
      cur_ff <= nxt_cur;
      pass_ff <= nxt_pass;
      oV_ff <= nxt_oV;
      oF_ff <= nxt_oF;
      oL_ff <= nxt_oL;
      oE_ff <= nxt_oE;
      oD_ff <= nxt_oD;
      lErr_ff <= nxt_lErr;
      oDat_ff <= nxt_oDat;
      oIdx_ff <= nxt_oIdx;
      idx_ff <= nxt_idx;
      sid_ff <= nxt_sid;
      size_ff <= nxt_size;
      mask_ff <= nxt_mask;
      tpl_ff <= nxt_tpl;
      hold_ff <= nxt_hold;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign outValid = oV_ff;
  assign outData = oDat_ff;
  assign outFirst = oF_ff;
  assign outLast = oL_ff;
  assign outElem = oE_ff;
  assign outIndex = oIdx_ff;
  assign outDrop = oD_ff;
  assign lookupErr = lErr_ff;
endmodule

// File: phs_regs.svh
// Register map, field layout and reset values of the header suppression block
// Functional notes
// - Sender strips repeated bytes after extended header; receiver restores them.
// - A rule always removes the same byte count, giving fixed header length.
// - Sender picks one flow and rule; receiver restores by identifier plus index.
// - Fully defined rule fields never change; replace by delete then install.
// - Deleting a classifier also deletes its associated suppression rule.
// - Bandwidth requests use post-suppression length; may not exceed grant size.
// - Headend assigns every index value when the rule is created.
// - Either side may supply the template and suppression size.
// - Suppression applies only to unicast flows, never to multicast traffic.
// - Voice flow of 42 bytes: verify, remove, add 2-byte index element.
// - Verify disabled, size 14: strip leading 14 bytes without checking.
// - Verify flag zero: compare masked bytes against template first.
// - On match remove masked bytes, write index into element, queue packet.
// - Failed verify: send whole without element; receiver restores only if present.
// - Upstream receiver looks up by identifier and index, rebuilds from template.
// - Downstream receiver looks up by index only and rebuilds the header.
// - Template and mask span the whole field, kept bytes restored in place.
// - Rules created by registration, add, change; deleted by change or delete.
// - Partial rule may complete later; then defaults apply, no changes allowed.
// - Table keyed by index and identifier upstream, index alone downstream.
// - The suppression index is an eight-bit value.
// - Size equals template byte length and count of valid mask bits.
`ifndef PHS_REGS_SVH
`define PHS_REGS_SVH
`define PHS_CTRL_OFS 12'h000
`define PHS_SEL_OFS 12'h004
`define PHS_CFG_OFS 12'h008
`define PHS_MASK_OFS 12'h00c
`define PHS_TPLA_OFS 12'h010
`define PHS_TPLD_OFS 12'h014
`define PHS_STAT_OFS 12'h018
`define PHS_CNT_OFS 12'h01c
`define PHS_CTRL_RST 32'h0000_0000
`define PHS_CTRL_UP_BIT 0
`define PHS_CFG_VFY_BIT 31
`define PHS_CFG_MC_BIT 30
`define PHS_CFG_DEL_BIT 29
`define PHS_CFG_TPL_BIT 28
`define PHS_CFG_SZ_BIT 27
`define PHS_ELEM_LEN 2
`endif

// File: phs_pkg.sv
// Types shared by the header suppression block
package phs_pkg;
  typedef enum logic [2:0] {
    PHS_IDLE = 3'b000,
    PHS_HDR = 3'b001,
    PHS_FLD = 3'b011,
    PHS_BODY = 3'b010,
    PHS_DROP = 3'b110
  } phs_state_e;
  typedef logic [7:0] phs_byte_t;
endpackage

// File: phs_core_assertions.sv
// Port-level checks for the header suppression core
`timescale 1ns/10ps
module phs_core_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic outValid,
  input wire logic outFirst,
  input wire logic outLast,
  input wire logic outDrop,
  input wire logic lookupErr
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence accessWait;
    psel && penable && !pready;
  endsequence
  sequence readyPulse;
    pready ##1 !pready;
  endsequence
  wait_state_a: assert property (accessWait |=> readyPulse)
    else $error("bus answer not one cycle after access");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  ready_cause_a: assert property ($rose(pready) |-> $past(penable))
    else $error("ready without prior access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("bus error without ready");
  first_valid_a: assert property (outFirst |-> outValid)
    else $error("first mark without byte");
  last_valid_a: assert property (outLast |-> outValid)
    else $error("last mark without byte");
  drop_quiet_a: assert property (outDrop |-> !outValid)
    else $error("byte sent while dropping");
  err_pulse_a: assert property (lookupErr |=> !lookupErr)
    else $error("lookup error held");
endmodule
bind phs_core phs_core_checker chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .outValid(outValid), .outFirst(outFirst),
  .outLast(outLast), .outDrop(outDrop), .lookupErr(lookupErr));

// File: phs_peer_model.sv
// Far-side receiver that gathers each packet leaving the core
`timescale 1ns/10ps
module phs_peer_model (
  input wire logic ref_clk,
  input wire logic outValid,
  input wire phs_pkg::phs_byte_t outData,
  input wire logic outElem,
  input wire logic [7:0] outIndex,
  input wire logic outDrop
);
  import phs_pkg::*;
  phs_byte_t rxBytes[$];
  logic rxElem = 1'b0;
  logic rxDrop = 1'b0;
  logic [7:0] rxIndex = 8'h00;
  always @(posedge ref_clk) begin
    if (outValid) begin
      rxBytes.push_back(outData);
    end
    if (outValid && outElem) begin
      rxElem = 1'b1;
      rxIndex = outIndex;
    end
    if (outDrop) begin
      rxDrop = 1'b1;
    end
  end
endmodule

// File: payload_header_suppression_test.sv
// Self-checking bench for the header suppression core
`timescale 1ns/10ps
module payload_header_suppression_test;
  import phs_pkg::*;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic inValid, inFirst, inLast, inElem, inMulti;
  logic [7:0] inIndex, outIndex;
  logic [13:0] inSid;
  logic [1:0] inRule;
  phs_byte_t inData, outData;
  logic outValid, outFirst, outLast, outElem, outDrop, lookupErr;
  int fail_count, total_checks;
  phs_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inValid(inValid), .inData(inData), .inFirst(inFirst),
    .inLast(inLast), .inElem(inElem), .inIndex(inIndex), .inSid(inSid),
    .inRule(inRule), .inMulti(inMulti), .outValid(outValid),
    .outData(outData), .outFirst(outFirst), .outLast(outLast),
    .outElem(outElem), .outIndex(outIndex), .outDrop(outDrop),
    .lookupErr(lookupErr));
  phs_peer_model peer (.ref_clk(ref_clk), .outValid(outValid),
    .outData(outData), .outElem(outElem), .outIndex(outIndex),
    .outDrop(outDrop));
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] ex, input logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("ready", 32'h1, {31'h0, pready});
    chk("slverr", {31'h0, er}, {31'h0, pslverr});
    if (!w && !er) chk("rdata", ex, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic pkt(input phs_byte_t b[$], input logic [1:0] r,
      input logic el, input logic [7:0] ix, input logic mc,
      input phs_byte_t e[$], input logic eEl, input logic [7:0] eIx);
    peer.rxBytes.delete();
    peer.rxElem = 1'b0;
    peer.rxDrop = 1'b0;
    foreach (b[i]) begin
      inValid <= 1'b1;
      inData <= b[i];
      inFirst <= (i == 0);
      inLast <= (i == b.size() - 1);
      inRule <= r;
      inElem <= el;
      inIndex <= ix;
      inMulti <= mc;
      @(posedge ref_clk);
      inValid <= 1'b0;
      repeat (16) @(posedge ref_clk);
    end
    repeat (30) @(posedge ref_clk);
    chk("count", 32'(e.size()), 32'(peer.rxBytes.size()));
    foreach (e[i]) chk("byte", {24'h0, e[i]}, {24'h0, peer.rxBytes[i]});
    chk("elem", {31'h0, eEl}, {31'h0, peer.rxElem});
    if (eEl) chk("index", {24'h0, eIx}, {24'h0, peer.rxIndex});
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Tests need about 1000 cycles
  initial begin
    repeat (8000) @(posedge ref_clk);
    fail_count++;
    test_done();
  end
  initial begin
    phs_byte_t q[$];
    phs_byte_t x[$];
    fail_count = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    inValid = 1'b0;
    inData = 8'h00;
    inFirst = 1'b0;
    inLast = 1'b0;
    inElem = 1'b0;
    inIndex = 8'h00;
    inSid = 14'h0123;
    inRule = 2'h0;
    inMulti = 1'b0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    bus(0, 12'h000, 0, 32'h0, 0);
    bus(1, 12'h000, 32'h1, 0, 0);
    bus(1, 12'h004, 32'h0, 0, 0);
    bus(1, 12'h00c, 32'hb, 0, 0);
    bus(1, 12'h010, 32'h0, 0, 0);
    for (int i = 0; i < 4; i++) bus(1, 12'h014, 32'(8'ha1 + 8'h11 * i), 0, 0);
    bus(1, 12'h008, 32'h1901_235a, 0, 0);
    bus(0, 12'h018, 0, 32'hf, 0);
    bus(1, 12'h00c, 32'h1, 0, 1);
    bus(1, 12'h008, 32'h1901_235a, 0, 1);
    bus(0, 12'h020, 0, 0, 1);
    bus(1, 12'h004, 32'h1, 0, 0);
    bus(1, 12'h00c, 32'h3fff, 0, 0);
    bus(1, 12'h010, 32'h0, 0, 0);
    for (int i = 0; i < 14; i++) bus(1, 12'h014, 32'(i), 0, 0);
    bus(1, 12'h008, 32'h9b81_2333, 0, 0);
    pkt('{8'ha1, 8'hb2, 8'h55, 8'hd4, 8'h01, 8'h02}, 0, 0, 0, 0,
      '{8'h55, 8'h01, 8'h02}, 1, 8'h5a);
    q = '{8'ha1, 8'h00, 8'hc3, 8'hd4, 8'h01};
    pkt(q, 0, 0, 0, 0, q, 0, 0);
    q = '{8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'h01};
    pkt(q, 0, 0, 0, 1, q, 0, 0);
    q.delete();
    for (int i = 0; i < 14; i++) q.push_back(8'(8'h80 + i));
    q.push_back(8'h01);
    x = '{8'h01};
    pkt(q, 1, 0, 0, 0, x, 1, 8'h33);
    bus(1, 12'h000, 32'h0, 0, 0);
    pkt('{8'h77, 8'h01}, 0, 1, 8'h5a, 0,
      '{8'ha1, 8'hb2, 8'h77, 8'hd4, 8'h01}, 0, 0);
    q = '{8'h10, 8'h20};
    pkt(q, 0, 0, 0, 0, q, 0, 0);
    x.delete();
    pkt('{8'h77, 8'h01}, 0, 1, 8'h99, 0, x, 0, 0);
    chk("drop", 32'h1, {31'h0, peer.rxDrop});
    bus(0, 12'h01c, 0, 32'h1, 0);
    bus(1, 12'h004, 32'h0, 0, 0);
    bus(1, 12'h008, 32'h2000_0000, 0, 0);
    bus(0, 12'h018, 0, 32'h0, 0);
    test_done();
  end
endmodule
